// ---- fpcf_pkg.sv ----
// ----------------------------------------------------------------------------
// How it works
// - Int compare: less 001, equal 100, unordered 111
// - Int compare writes zero/parity/carry; greater clears all
// - Cond compare: greater 000, less 001, equal 100, unord 111
// - Feature bit reports int-flag compare support
// - Unordered variants: no invalid on quiet NaN
// - Popping forms pop stack after compare
// - Examine classifies top value into condition bits
// - Examine sets cond bit one to sign
// - No direct branch; status word must be copied
// - Store status copies word to accumulator
// - Cond bit two sits at mask 0400
// - Cond masks 0100, 0400, 4000; combined 4500
// ----------------------------------------------------------------------------
package fpcf_pkg;

  // --------------------------------------------------------------------------
  // Register map (byte addresses)
  // --------------------------------------------------------------------------
  localparam logic [11:0] OFS_CMD      = 12'h000;
  localparam logic [11:0] OFS_OPA_LO   = 12'h004;
  localparam logic [11:0] OFS_OPA_MID  = 12'h008;
  localparam logic [11:0] OFS_OPA_HI   = 12'h00c;
  localparam logic [11:0] OFS_OPB_LO   = 12'h010;
  localparam logic [11:0] OFS_OPB_MID  = 12'h014;
  localparam logic [11:0] OFS_OPB_HI   = 12'h018;
  localparam logic [11:0] OFS_STATUS   = 12'h01c;
  localparam logic [11:0] OFS_IFLAGS   = 12'h020;
  localparam logic [11:0] OFS_ACC      = 12'h024;
  localparam logic [11:0] OFS_FEATURE  = 12'h028;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h02c;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h030;
  localparam logic [11:0] OFS_TOP      = 12'h034;

  // --------------------------------------------------------------------------
  // Status word bit positions
  // --------------------------------------------------------------------------
  localparam int IE_POS   = 0;
  localparam int C0_POS   = 8;
  localparam int C1_POS   = 9;
  localparam int C2_POS   = 10;
  localparam int TOP_POS  = 11;
  localparam int C3_POS   = 14;
  localparam logic [15:0] MASK_UNORD = 16'h0400;
  localparam logic [15:0] MASK_LESS  = 16'h0100;
  localparam logic [15:0] MASK_EQUAL = 16'h4000;
  localparam logic [15:0] MASK_ALL   = 16'h4500;

  // Integer flag positions within the integer flag register.
  localparam int CF_POS = 0;
  localparam int PF_POS = 2;
  localparam int ZF_POS = 6;

  // Feature word bit for integer-flag compare support.
  localparam int FEAT_CMPI_POS = 15;

  // Interrupt status bits.
  localparam int IRQ_DONE_POS  = 0;
  localparam int IRQ_INV_POS   = 1;
  localparam int IRQ_WIDTH     = 2;

  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [2:0]  TOP_RST    = 3'h0;

  // --------------------------------------------------------------------------
  // Commands and classes
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_NONE      = 4'h0,
    CMD_COMI      = 4'h1,
    CMD_COMIP     = 4'h2,
    CMD_UCOMI     = 4'h3,
    CMD_UCOMIP    = 4'h4,
    CMD_COM       = 4'h5,
    CMD_COMP      = 4'h6,
    CMD_XAM       = 4'h7,
    CMD_STSW_ACC  = 4'h8
  } fpcf_cmd_t;

  typedef enum logic [1:0] {
    REL_GT,
    REL_LT,
    REL_EQ,
    REL_UN
  } fpcf_rel_t;

  // Condition codes C3,C2,C0 per examine class (C1 carries the sign).
  localparam logic [2:0] XAM_UNSUP  = 3'b000;
  localparam logic [2:0] XAM_NAN    = 3'b001;
  localparam logic [2:0] XAM_NORMAL = 3'b010;
  localparam logic [2:0] XAM_INF    = 3'b011;
  localparam logic [2:0] XAM_ZERO   = 3'b100;
  localparam logic [2:0] XAM_EMPTY  = 3'b101;
  localparam logic [2:0] XAM_DENORM = 3'b110;

endpackage : fpcf_pkg

// ---- fpcf_compare.sv ----
`timescale 1ns/1ps
// Combinational compare of two 80-bit extended values and classify of the first.
module fpcf_compare
(
  // Operands
  input  wire logic [79:0]  opa,
  input  wire logic [79:0]  opb,
  input  wire logic         opa_empty,
  // Results
  output fpcf_pkg::fpcf_rel_t rel,
  output logic              any_snan,
  output logic              any_nan,
  output logic [2:0]        xam_class
);

  function automatic logic is_nan(input logic [79:0] v);
    is_nan = (v[78:64] == 15'h7fff) && v[63] && (v[62:0] != 63'h0);
  endfunction : is_nan

  function automatic logic is_unsup(input logic [79:0] v);
    is_unsup = (v[78:64] != 15'h0000) && !v[63];
  endfunction : is_unsup

  function automatic logic is_zero(input logic [79:0] v);
    is_zero = (v[78:64] == 15'h0000) && (v[63:0] == 64'h0);
  endfunction : is_zero

  logic       a_nan;
  logic       b_nan;
  logic       unord;
  logic [78:0] mag_a;
  logic [78:0] mag_b;

  assign a_nan    = is_nan(opa);
  assign b_nan    = is_nan(opb);
  assign unord    = a_nan || b_nan || is_unsup(opa) || is_unsup(opb);
  assign any_nan  = a_nan || b_nan;
  // A signalling NaN has the quiet bit clear.
  assign any_snan = (a_nan && !opa[62]) || (b_nan && !opb[62]);
  assign mag_a    = opa[78:0];
  assign mag_b    = opb[78:0];

  always_comb
  begin
    if (unord)
      rel = fpcf_pkg::REL_UN;
    else if ((is_zero(opa) && is_zero(opb)) || (opa == opb))
      rel = fpcf_pkg::REL_EQ;
    else if (opa[79] != opb[79])
      rel = opa[79] ? fpcf_pkg::REL_LT : fpcf_pkg::REL_GT;
    else if ((mag_a < mag_b) != opa[79])
      rel = fpcf_pkg::REL_LT;
    else
      rel = fpcf_pkg::REL_GT;
  end

  always_comb
  begin
    if (opa_empty)
      xam_class = fpcf_pkg::XAM_EMPTY;
    else if (is_unsup(opa))
      xam_class = fpcf_pkg::XAM_UNSUP;
    else if (a_nan)
      xam_class = fpcf_pkg::XAM_NAN;
    else if (opa[78:64] == 15'h7fff)
      xam_class = fpcf_pkg::XAM_INF;
    else if (is_zero(opa))
      xam_class = fpcf_pkg::XAM_ZERO;
    else if (opa[78:64] == 15'h0000)
      xam_class = fpcf_pkg::XAM_DENORM;
    else
      xam_class = fpcf_pkg::XAM_NORMAL;
  end

endmodule : fpcf_compare

// ---- fpcf_top.sv ----
`timescale 1ns/1ps
module fpcf_top
#(
  parameter int STACK_DEPTH = 8
)
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Interrupt
  output logic             irq
);

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  fpcf_pkg::fpcf_cmd_t cmd;

  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !penable && !pwrite;
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= fpcf_pkg::OFS_TOP);
  assign pslverr = psel && penable && !addr_ok;
  assign cmd     = fpcf_pkg::fpcf_cmd_t'(pwdata[3:0]);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [79:0] opa_q;
  logic [79:0] opb_q;
  logic [15:0] status_q;
  logic [31:0] iflags_q;
  logic [15:0] acc_q;
  logic [fpcf_pkg::IRQ_WIDTH-1:0] irq_stat_q;
  logic [fpcf_pkg::IRQ_WIDTH-1:0] irq_mask_q;
  logic [STACK_DEPTH-1:0] tag_full_q;
  logic [2:0]  top_q;
  logic        cmd_go;

  fpcf_pkg::fpcf_rel_t rel;
  logic        any_snan;
  logic        any_nan;
  logic [2:0]  xam_class;

  fpcf_compare u_compare
  (
    .opa       (opa_q),
    .opb       (opb_q),
    .opa_empty (!tag_full_q[top_q]),
    .rel       (rel),
    .any_snan  (any_snan),
    .any_nan   (any_nan),
    .xam_class (xam_class)
  );

  assign cmd_go = wr_en && (paddr == fpcf_pkg::OFS_CMD);

  // Invalid: ordinary compares fault on any unordered result, unordered ones unless a quiet NaN and no sNaN is present.
  logic is_cmpi;
  logic is_ucmpi;
  logic is_pop;
  logic invalid;

  assign is_cmpi  = cmd_go && (cmd == fpcf_pkg::CMD_COMI || cmd == fpcf_pkg::CMD_COMIP);
  assign is_ucmpi = cmd_go && (cmd == fpcf_pkg::CMD_UCOMI || cmd == fpcf_pkg::CMD_UCOMIP);
  assign is_pop   = cmd_go && (cmd == fpcf_pkg::CMD_COMIP || cmd == fpcf_pkg::CMD_UCOMIP
                               || cmd == fpcf_pkg::CMD_COMP);
  assign invalid  = (is_cmpi && (rel == fpcf_pkg::REL_UN) && (any_nan || !any_snan))
                 || (is_ucmpi && (rel == fpcf_pkg::REL_UN) && !(any_nan && !any_snan));

  // --------------------------------------------------------------------------
  // Operand registers
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      opa_q <= 80'h0;
      opb_q <= 80'h0;
    end
    else if (wr_en)
    begin
      case (paddr)
        fpcf_pkg::OFS_OPA_LO:  opa_q[31:0]  <= pwdata;
        fpcf_pkg::OFS_OPA_MID: opa_q[63:32] <= pwdata;
        fpcf_pkg::OFS_OPA_HI:  opa_q[79:64] <= pwdata[15:0];
        fpcf_pkg::OFS_OPB_LO:  opb_q[31:0]  <= pwdata;
        fpcf_pkg::OFS_OPB_MID: opb_q[63:32] <= pwdata;
        fpcf_pkg::OFS_OPB_HI:  opb_q[79:64] <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Stack tags and top pointer
  // --------------------------------------------------------------------------
  // Writing the top operand's high word marks the top slot full; a pop empties
  // it and moves the pointer, so a later examine reads the next slot, which is empty unless written.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tag_full_q <= '0;
      top_q      <= fpcf_pkg::TOP_RST;
    end
    else if (is_pop)
    begin
      tag_full_q[top_q] <= 1'b0;
      top_q             <= top_q + 3'd1;
    end
    else if (wr_en && paddr == fpcf_pkg::OFS_OPA_HI)
      tag_full_q[top_q] <= 1'b1;
  end

  // --------------------------------------------------------------------------
  // Floating-point status word
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_q <= fpcf_pkg::STATUS_RST;
    else if (cmd_go && (cmd == fpcf_pkg::CMD_COM || cmd == fpcf_pkg::CMD_COMP))
    begin
      // Bit placement gives software its fixed test masks.
      case (rel)
        fpcf_pkg::REL_GT:
        begin
          status_q[fpcf_pkg::C3_POS] <= 1'b0;
          status_q[fpcf_pkg::C2_POS] <= 1'b0;
          status_q[fpcf_pkg::C0_POS] <= 1'b0;
        end
        fpcf_pkg::REL_LT:
        begin
          status_q[fpcf_pkg::C3_POS] <= 1'b0;
          status_q[fpcf_pkg::C2_POS] <= 1'b0;
          status_q[fpcf_pkg::C0_POS] <= 1'b1;
        end
        fpcf_pkg::REL_EQ:
        begin
          status_q[fpcf_pkg::C3_POS] <= 1'b1;
          status_q[fpcf_pkg::C2_POS] <= 1'b0;
          status_q[fpcf_pkg::C0_POS] <= 1'b0;
        end
        default:
        begin
          status_q[fpcf_pkg::C3_POS] <= 1'b1;
          status_q[fpcf_pkg::C2_POS] <= 1'b1;
          status_q[fpcf_pkg::C0_POS] <= 1'b1;
        end
      endcase
      status_q[fpcf_pkg::IE_POS] <= status_q[fpcf_pkg::IE_POS] || (rel == fpcf_pkg::REL_UN);
      status_q[fpcf_pkg::TOP_POS +: 3] <= (cmd == fpcf_pkg::CMD_COMP) ? top_q + 3'd1 : top_q;
    end
    else if (cmd_go && cmd == fpcf_pkg::CMD_XAM)
    begin
      status_q[fpcf_pkg::C3_POS] <= xam_class[2];
      status_q[fpcf_pkg::C2_POS] <= xam_class[1];
      status_q[fpcf_pkg::C0_POS] <= xam_class[0];
      status_q[fpcf_pkg::C1_POS] <= opa_q[79];
    end
    else if (is_cmpi || is_ucmpi)
    begin
      // Only the exception flag and stack top move; condition bits stay.
      status_q[fpcf_pkg::IE_POS] <= status_q[fpcf_pkg::IE_POS] || invalid;
      status_q[fpcf_pkg::TOP_POS +: 3] <= is_pop ? top_q + 3'd1 : top_q;
    end
    else if (wr_en && paddr == fpcf_pkg::OFS_STATUS)
      status_q[fpcf_pkg::IE_POS] <= status_q[fpcf_pkg::IE_POS] && !pwdata[fpcf_pkg::IE_POS];
  end

  // --------------------------------------------------------------------------
  // Integer flag register
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      iflags_q <= 32'h0;
    else if (is_cmpi || is_ucmpi)
    begin
      iflags_q[fpcf_pkg::ZF_POS] <= (rel == fpcf_pkg::REL_EQ) || (rel == fpcf_pkg::REL_UN);
      iflags_q[fpcf_pkg::PF_POS] <= (rel == fpcf_pkg::REL_UN);
      iflags_q[fpcf_pkg::CF_POS] <= (rel == fpcf_pkg::REL_LT) || (rel == fpcf_pkg::REL_UN);
    end
    // Greater clears all three through the expressions above.
  end

  // --------------------------------------------------------------------------
  // Accumulator copy of status word
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      acc_q <= 16'h0;
    else if (cmd_go && cmd == fpcf_pkg::CMD_STSW_ACC)
      acc_q <= status_q;
  end

  // --------------------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------------------
  logic [fpcf_pkg::IRQ_WIDTH-1:0] irq_set;

  assign irq_set[fpcf_pkg::IRQ_DONE_POS] = cmd_go && (cmd != fpcf_pkg::CMD_NONE);
  assign irq_set[fpcf_pkg::IRQ_INV_POS]  = invalid;

  // A set in the same cycle as a write-one clear wins over the clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat_q <= '0;
    else if (wr_en && paddr == fpcf_pkg::OFS_IRQ_STAT)
      irq_stat_q <= (irq_stat_q & ~pwdata[fpcf_pkg::IRQ_WIDTH-1:0]) | irq_set;
    else
      irq_stat_q <= irq_stat_q | irq_set;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask_q <= '0;
    else if (wr_en && paddr == fpcf_pkg::OFS_IRQ_MASK)
      irq_mask_q <= pwdata[fpcf_pkg::IRQ_WIDTH-1:0];
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  logic [31:0] rd_d;

  always_comb
  begin
    rd_d = 32'h0;
    case (paddr)
      fpcf_pkg::OFS_OPA_LO:   rd_d = opa_q[31:0];
      fpcf_pkg::OFS_OPA_MID:  rd_d = opa_q[63:32];
      fpcf_pkg::OFS_OPA_HI:   rd_d = {16'h0, opa_q[79:64]};
      fpcf_pkg::OFS_OPB_LO:   rd_d = opb_q[31:0];
      fpcf_pkg::OFS_OPB_MID:  rd_d = opb_q[63:32];
      fpcf_pkg::OFS_OPB_HI:   rd_d = {16'h0, opb_q[79:64]};
      fpcf_pkg::OFS_STATUS:   rd_d = {16'h0, status_q};
      fpcf_pkg::OFS_IFLAGS:   rd_d = iflags_q;
      fpcf_pkg::OFS_ACC:      rd_d = {16'h0, acc_q};
      fpcf_pkg::OFS_FEATURE:  rd_d = 32'h1 << fpcf_pkg::FEAT_CMPI_POS;
      fpcf_pkg::OFS_IRQ_STAT: rd_d = {30'h0, irq_stat_q};
      fpcf_pkg::OFS_IRQ_MASK: rd_d = {30'h0, irq_mask_q};
      fpcf_pkg::OFS_TOP:      rd_d = {29'h0, top_q};
      default:                rd_d = 32'h0;
    endcase
  end

  // Read data is captured at the end of the setup cycle, so it stands from a
  // flip-flop through the whole access cycle and is zero otherwise.
  logic [31:0] prdata_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0;
    else
      prdata_q <= rd_en ? rd_d : 32'h0;
  end

  assign prdata = prdata_q;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  a_cmpi_flags_eq: assert property (@(posedge pclk) disable iff (!presetn)
    (is_cmpi || is_ucmpi) && rel == fpcf_pkg::REL_EQ |=> iflags_q[6:0] == 7'b1000000)
    else $error("equal compare flags wrong");

  a_cmpi_flags_gt: assert property (@(posedge pclk) disable iff (!presetn)
    (is_cmpi || is_ucmpi) && rel == fpcf_pkg::REL_GT |=> iflags_q[6:0] == 7'b0000000)
    else $error("greater compare flags not cleared");

  a_cond_unord: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_go && cmd == fpcf_pkg::CMD_COM && rel == fpcf_pkg::REL_UN
    |=> (status_q & fpcf_pkg::MASK_ALL) == fpcf_pkg::MASK_ALL)
    else $error("unordered condition code wrong");

  a_pop_moves_top: assert property (@(posedge pclk) disable iff (!presetn)
    is_pop |=> top_q == $past(top_q) + 3'd1)
    else $error("pop did not move top");

  a_xam_sign: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_go && cmd == fpcf_pkg::CMD_XAM |=> status_q[fpcf_pkg::C1_POS] == $past(opa_q[79]))
    else $error("examine sign wrong");

  a_acc_copy: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_go && cmd == fpcf_pkg::CMD_STSW_ACC |=> acc_q == $past(status_q))
    else $error("accumulator copy wrong");

  a_cc_kept: assert property (@(posedge pclk) disable iff (!presetn)
    is_cmpi || is_ucmpi |=> status_q[fpcf_pkg::C3_POS] == $past(status_q[fpcf_pkg::C3_POS])
    && status_q[fpcf_pkg::C2_POS] == $past(status_q[fpcf_pkg::C2_POS])
    && status_q[fpcf_pkg::C0_POS] == $past(status_q[fpcf_pkg::C0_POS]))
    else $error("condition bits changed");

  a_quiet_no_inv: assert property (@(posedge pclk) disable iff (!presetn)
    is_ucmpi && any_nan && !any_snan |-> !invalid)
    else $error("quiet NaN raised invalid");

  a_unord_mask: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_go && (cmd == fpcf_pkg::CMD_COM || cmd == fpcf_pkg::CMD_COMP)
    |=> ((status_q & fpcf_pkg::MASK_UNORD) != 16'h0000) == ($past(rel) == fpcf_pkg::REL_UN))
    else $error("unordered mask bit wrong");

  a_gt_mask_zero: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_go && (cmd == fpcf_pkg::CMD_COM || cmd == fpcf_pkg::CMD_COMP) && rel == fpcf_pkg::REL_GT
    |=> (status_q & fpcf_pkg::MASK_ALL) == 16'h0000)
    else $error("greater result not zero under combined mask");

  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    invalid && irq_mask_q[fpcf_pkg::IRQ_INV_POS] |=> irq)
    else $error("enabled invalid gave no interrupt");

  c_unord_cmpi: cover property (@(posedge pclk) disable iff (!presetn)
    is_cmpi && rel == fpcf_pkg::REL_UN);
  c_pop: cover property (@(posedge pclk) disable iff (!presetn) is_pop);
  c_xam_empty: cover property (@(posedge pclk) disable iff (!presetn)
    cmd_go && cmd == fpcf_pkg::CMD_XAM && xam_class == fpcf_pkg::XAM_EMPTY);

endmodule : fpcf_top

// ---- fpcf_sw_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Software side of the block: issues APB transfers one at a time
// ----------------------------------------------------------------------------
module fpcf_sw_model
(
  // Clock
  input  wire logic        pclk,
  // APB master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata
);
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end

  // The request is held until pready is seen high, so a slow slave is safe.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : fpcf_sw_model

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
  // --------------------------------------------------------------------------
  // Signals and constants
  // --------------------------------------------------------------------------
  localparam int          LIMIT = 5000;
  localparam logic [79:0] ONE   = 80'h3fff_8000_0000_0000_0000;
  localparam logic [79:0] TWO   = 80'h4000_8000_0000_0000_0000;
  localparam logic [79:0] QNAN  = 80'h7fff_c000_0000_0000_0000;
  localparam logic [79:0] SNAN  = 80'h7fff_a000_0000_0000_0000;
  localparam logic [79:0] NINF  = 80'hffff_8000_0000_0000_0000;
  localparam logic [79:0] NZER  = 80'h8000_0000_0000_0000_0000;
  localparam logic [79:0] DEN   = 80'h0000_0000_0000_0000_0001;
  localparam logic [79:0] UNS   = 80'h3fff_0000_0000_0000_0000;

  typedef struct {
    fpcf_pkg::fpcf_cmd_t cmd;
    logic [79:0]         a;
    logic [79:0]         b;
    logic [31:0]         fl;
    logic [15:0]         cc;
    logic [15:0]         msk;
  } fpcf_row_t;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic        irq;
  int          n_fail;
  int          n_tests;
  int          cyc;
  fpcf_row_t   rows [16];

  always #2.5 pclk = ~pclk;

  fpcf_top #(.STACK_DEPTH(8)) dut_u
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .irq(irq)
  );

  fpcf_sw_model sw_u
  (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata)
  );

  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task automatic close_out;
    if (n_fail == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    sw_u.xfer(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m,
                    input logic ee);
    logic [31:0] r;
    logic        e;
    sw_u.xfer(1'b0, a, 32'h0000_0000, r, e);
    check({31'h0, e}, {31'h0, ee}, "pslverr");
    check(r & m, exp, "prdata");
  endtask : rd

  // Writing the first operand's high part, after its low and middle parts, marks the top slot as holding a value.
  task automatic ld(input logic [79:0] a, input logic [79:0] b);
    wr(fpcf_pkg::OFS_OPA_LO, a[31:0]);
    wr(fpcf_pkg::OFS_OPA_MID, a[63:32]);
    wr(fpcf_pkg::OFS_OPA_HI, {16'h0000, a[79:64]});
    wr(fpcf_pkg::OFS_OPB_LO, b[31:0]);
    wr(fpcf_pkg::OFS_OPB_MID, b[63:32]);
    wr(fpcf_pkg::OFS_OPB_HI, {16'h0000, b[79:64]});
  endtask : ld

  task automatic cmd(input fpcf_pkg::fpcf_cmd_t c);
    wr(fpcf_pkg::OFS_CMD, {28'h0000000, c});
  endtask : cmd

  // The interrupt follows registers, so let the update edge pass first.
  task automatic irq_is(input logic exp);
    repeat (2) @(negedge pclk);
    check({31'h0, irq}, {31'h0, exp}, "irq");
  endtask : irq_is

  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      n_fail++;
      close_out();
    end
  end

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial
  begin
    pclk    = 1'b0;
    presetn = 1'b0;
    n_fail  = 0;
    n_tests = 0;
    cyc     = 0;
    rows = '{
      '{fpcf_pkg::CMD_COMI,  TWO,  ONE,  32'h00, 16'h0000, 16'h4500},
      '{fpcf_pkg::CMD_COMI,  ONE,  TWO,  32'h01, 16'h0000, 16'h4500},
      '{fpcf_pkg::CMD_COM,   ONE,  TWO,  32'h01, 16'h0100, 16'h4500},
      '{fpcf_pkg::CMD_COMI,  ONE,  ONE,  32'h40, 16'h0100, 16'h4500},
      '{fpcf_pkg::CMD_COM,   TWO,  ONE,  32'h40, 16'h0000, 16'h4500},
      '{fpcf_pkg::CMD_COM,   ONE,  ONE,  32'h40, 16'h4000, 16'h4500},
      '{fpcf_pkg::CMD_COMI,  QNAN, ONE,  32'h45, 16'h4000, 16'h4500},
      '{fpcf_pkg::CMD_COM,   ONE,  QNAN, 32'h45, 16'h4500, 16'h4500},
      '{fpcf_pkg::CMD_UCOMI, TWO,  ONE,  32'h00, 16'h4500, 16'h4500},
      '{fpcf_pkg::CMD_XAM,   '0,   ONE,  32'h00, 16'h4000, 16'h4700},
      '{fpcf_pkg::CMD_XAM,   NZER, ONE,  32'h00, 16'h4200, 16'h4700},
      '{fpcf_pkg::CMD_XAM,   ONE,  ONE,  32'h00, 16'h0400, 16'h4700},
      '{fpcf_pkg::CMD_XAM,   NINF, ONE,  32'h00, 16'h0700, 16'h4700},
      '{fpcf_pkg::CMD_XAM,   QNAN, ONE,  32'h00, 16'h0100, 16'h4700},
      '{fpcf_pkg::CMD_XAM,   DEN,  ONE,  32'h00, 16'h4400, 16'h4700},
      '{fpcf_pkg::CMD_XAM,   UNS,  ONE,  32'h00, 16'h0000, 16'h4700}};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    irq_is(1'b0);
    rd(fpcf_pkg::OFS_STATUS, 32'h0, 32'hffff_ffff, 1'b0);
    rd(fpcf_pkg::OFS_IFLAGS, 32'h0, 32'hffff_ffff, 1'b0);
    rd(fpcf_pkg::OFS_TOP, 32'h0, 32'hffff_ffff, 1'b0);
    rd(fpcf_pkg::OFS_FEATURE, 32'h8000, 32'h8000, 1'b0);
    rd(12'h038, 32'h0, 32'hffff_ffff, 1'b1);
    rd(12'h006, 32'h0, 32'hffff_ffff, 1'b1);
    // Each row reads both flag sets straight after its command.
    for (int i = 0; i < 16; i++)
    begin
      ld(rows[i].a, rows[i].b);
      cmd(rows[i].cmd);
      rd(fpcf_pkg::OFS_STATUS, {16'h0, rows[i].cc}, {16'h0, rows[i].msk}, 1'b0);
      rd(fpcf_pkg::OFS_IFLAGS, rows[i].fl, 32'h45, 1'b0);
    end
    wr(fpcf_pkg::OFS_IRQ_STAT, 32'h3);
    wr(fpcf_pkg::OFS_IRQ_MASK, 32'h2);
    ld(QNAN, ONE);
    cmd(fpcf_pkg::CMD_UCOMI);
    irq_is(1'b0);
    rd(fpcf_pkg::OFS_IRQ_STAT, 32'h1, 32'h3, 1'b0);
    cmd(fpcf_pkg::CMD_COMI);
    irq_is(1'b1);
    rd(fpcf_pkg::OFS_IRQ_STAT, 32'h3, 32'h3, 1'b0);
    rd(fpcf_pkg::OFS_STATUS, 32'h1, 32'h1, 1'b0);
    wr(fpcf_pkg::OFS_STATUS, 32'h1);
    rd(fpcf_pkg::OFS_STATUS, 32'h0, 32'h1, 1'b0);
    wr(fpcf_pkg::OFS_IRQ_STAT, 32'h2);
    irq_is(1'b0);
    ld(SNAN, ONE);
    cmd(fpcf_pkg::CMD_UCOMI);
    irq_is(1'b1);
    wr(fpcf_pkg::OFS_IRQ_MASK, 32'h0);
    irq_is(1'b0);
    // A pop leaves the new top empty, which the examine must report.
    ld(ONE, TWO);
    cmd(fpcf_pkg::CMD_COMIP);
    rd(fpcf_pkg::OFS_IFLAGS, 32'h01, 32'h45, 1'b0);
    rd(fpcf_pkg::OFS_TOP, 32'h1, 32'h7, 1'b0);
    cmd(fpcf_pkg::CMD_XAM);
    rd(fpcf_pkg::OFS_STATUS, 32'h4900, 32'h7d00, 1'b0);
    cmd(fpcf_pkg::CMD_STSW_ACC);
    rd(fpcf_pkg::OFS_ACC, 32'h4900, 32'hffff_7d00, 1'b0);
    ld(TWO, ONE);
    cmd(fpcf_pkg::CMD_UCOMIP);
    rd(fpcf_pkg::OFS_IFLAGS, 32'h00, 32'h45, 1'b0);
    rd(fpcf_pkg::OFS_TOP, 32'h2, 32'h7, 1'b0);
    ld(ONE, ONE);
    cmd(fpcf_pkg::CMD_COMP);
    rd(fpcf_pkg::OFS_STATUS, 32'h5800, 32'h7d00, 1'b0);
    rd(fpcf_pkg::OFS_IFLAGS, 32'h00, 32'h45, 1'b0);
    rd(fpcf_pkg::OFS_TOP, 32'h3, 32'h7, 1'b0);
    close_out();
  end
endmodule : tb
